// *** include/pbcf_defines.svh ***
`ifndef PBCF_DEFINES_SVH
`define PBCF_DEFINES_SVH

// device measurement registers
`define PBCF_REG_MEAS_A 8'h11
`define PBCF_REG_MEAS_B 8'h12
`define PBCF_MEAS_RESET 24'h000000
`define PBCF_EXT_SEL_OFF 2'h3

// frame layout
`define PBCF_SEL_IDENT 5'h00
`define PBCF_SEL_EE_WR 5'h01
`define PBCF_SEL_EE_RD 5'h02
`define PBCF_LEN_IDENT_REQ 4'h3
`define PBCF_LEN_IDENT_REPLY 4'h9
`define PBCF_LEN_EE_WR 4'hd
`define PBCF_LEN_EE_RD 4'h5
`define PBCF_FIRST_IDENTIFIER_BYTE_TAG 2'h3
`define PBCF_SECOND_IDENTIFIER_BYTE_TAG 2'h0
`define PBCF_BCAST_BIT 7
`define PBCF_EE_DATA_FIRST 4

// checksum
`define PBCF_CRC_POLY 8'h07
`define PBCF_CRC_INIT 8'hff

// eeprom status codes
`define PBCF_EES_DENIED 2'h0
`define PBCF_EES_ONGOING 2'h1
`define PBCF_EES_DONE 2'h2
`define PBCF_EES_FAILED 2'h3
`define PBCF_EES_RESET 2'h2

// controller command registers
`define PBCF_HREG_CMD 8'h00
`define PBCF_HREG_EE_ADDR 8'h04
`define PBCF_HREG_DATA_LO 8'h08
`define PBCF_HREG_DATA_HI 8'h0c
`define PBCF_HREG_STATUS 8'h10
`define PBCF_HREG_ID0 8'h14
`define PBCF_HREG_ID1 8'h18

// reply timeout
`define PBCF_REPLY_TIMEOUT_NS 10000
`define PBCF_CLK_PERIOD_NS 10
`define PBCF_REPLY_TIMEOUT_CYC (`PBCF_REPLY_TIMEOUT_NS / `PBCF_CLK_PERIOD_NS)

`endif

// *** include/pbcf_pkg.sv ***
`include "pbcf_defines.svh"

package pbcf_pkg;

    typedef enum logic [1:0] {
        PBCF_D_IDLE = 2'h0,
        PBCF_D_RX = 2'h1,
        PBCF_D_EXEC = 2'h3,
        PBCF_D_REPLY = 2'h2
    } pbcf_dev_state_t;

    typedef enum logic [1:0] {
        PBCF_H_IDLE = 2'h0,
        PBCF_H_SEND = 2'h1,
        PBCF_H_WAIT = 2'h3,
        PBCF_H_DONE = 2'h2
    } pbcf_host_state_t;

    typedef logic [7:0] pbcf_byte_t;

    // bit 7 makes the byte even parity over bits 0..6
    function automatic logic pbcf_parity(input pbcf_byte_t b);
        return ^b[6:0];
    endfunction : pbcf_parity

    function automatic pbcf_byte_t pbcf_crc_step(input pbcf_byte_t crc, input pbcf_byte_t b);
        pbcf_byte_t c;
        c = crc ^ b;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ `PBCF_CRC_POLY) : (c << 1);
        end
        return c;
    endfunction : pbcf_crc_step

    function automatic logic [3:0] pbcf_frame_len(input logic [4:0] sel);
        if (sel == `PBCF_SEL_EE_WR) begin
            return `PBCF_LEN_EE_WR;
        end else if (sel == `PBCF_SEL_EE_RD) begin
            return `PBCF_LEN_EE_RD;
        end
        return `PBCF_LEN_IDENT_REQ;
    endfunction : pbcf_frame_len

endpackage : pbcf_pkg

// *** include/pbcf_if.sv ***
`timescale 1ns/10ps

interface pbcf_if;
    logic [7:0] m2s_data;
    logic m2s_first;
    logic m2s_valid;
    logic m2s_ready;
    logic [7:0] s2m_data;
    logic s2m_valid;
    logic s2m_ready;

    modport device (
        input m2s_data, m2s_first, m2s_valid, s2m_ready,
        output m2s_ready, s2m_data, s2m_valid
    );
    modport host (
        output m2s_data, m2s_first, m2s_valid, s2m_ready,
        input m2s_ready, s2m_data, s2m_valid
    );
endinterface : pbcf_if

// *** rtl/pbcf_device.sv ***
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
`include "pbcf_defines.svh"

module pbcf_fifo import pbcf_pkg::*; #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic rdy_q, rdy_d, vld_q, vld_d, push, pop;

    always_comb begin
        push = in_valid && rdy_q;
        pop = out_ready && vld_q;
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        // flags are registered so the ready seen by the sender is a clean flop
        rdy_d = cnt_d != (AW+1)'(DEPTH);
        vld_d = cnt_d != '0;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b0;
            vld_q <= 1'b0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
            vld_q <= vld_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    assign in_ready = rdy_q;
    assign out_valid = vld_q;
    assign out_data = mem_q[rd_q];
endmodule : pbcf_fifo

module pbcf_device import pbcf_pkg::*; #(
    parameter logic [7:0] DEVICE_ID = 8'h5a, // arbitrary value
    parameter logic [7:0] ANALOG_VER = 8'h0a, // arbitrary value
    parameter logic [7:0] DIGITAL_VER = 8'h0b, // arbitrary value
    parameter logic [4:0] WAFER_WIDTH = 5'h00,
    parameter logic [7:0] WAFER_X = 8'h00,
    parameter logic [7:0] WAFER_Y = 8'h00
) (
    input wire logic clk_sys,
    input wire logic reset,
    pbcf_if.device link,
    input wire logic [4:0] own_slave_address,
    input wire logic meas_update,
    input wire logic [7:0] temperature_result,
    input wire logic [7:0] core_supply_result,
    input wire logic [7:0] external_channel_result,
    input wire logic [1:0] external_channel_select,
    input wire logic [7:0] battery_voltage_result,
    input wire logic [7:0] string_voltage_result,
    input wire logic [7:0] overheat_threshold_code,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    output logic [23:0] reg_rdata_q,
    output logic ee_wr_q,
    output logic ee_rd_q,
    output logic [2:0] ee_dev_q,
    output logic [7:0] ee_addr_q,
    output logic [63:0] ee_data_q,
    input wire logic ee_done,
    input wire logic ee_fail,
    output logic [1:0] eeprom_access_state_q,
    output logic frame_error_q
);
    pbcf_dev_state_t st_q, st_d;
    pbcf_byte_t buf_q [13];
    pbcf_byte_t buf_d [13];
    pbcf_byte_t crc_q, crc_d, tcrc_q, tcrc_d, txd_q, txd_d, rb;
    logic [3:0] idx_q, idx_d, len_q, len_d, tidx_q, tidx_d, len_x;
    logic err_q, err_d, crcok_q, crcok_d, txv_q, txv_d, busy_q, busy_d;
    logic wr_d, rd_d, ferr_d, pop, f_valid, f_first, own, take;
    logic [1:0] ees_d;
    logic [2:0] dev_d;
    logic [7:0] addr_d, f_data;
    logic [63:0] data_d;
    logic [23:0] meas_a_q, meas_b_q, rdata_d;

    pbcf_fifo #(.WIDTH(9), .DEPTH(16)) u_fifo (
        .clk_sys(clk_sys),
        .reset(reset),
        .in_valid(link.m2s_valid),
        .in_ready(link.m2s_ready),
        .in_data({link.m2s_first, link.m2s_data}),
        .out_valid(f_valid),
        .out_ready(pop),
        .out_data({f_first, f_data})
    );

    function automatic logic pid_bad(input pbcf_byte_t b, input logic [1:0] tag);
        return (b[7] != pbcf_parity(b)) || (b[6:5] != tag);
    endfunction : pid_bad

    always_comb begin
        // reply bytes in wire order
        case (tidx_q)
            4'h0: rb = buf_q[0];
            4'h1: rb = buf_q[1];
            4'h2: rb = DEVICE_ID;
            4'h3: rb = ANALOG_VER;
            4'h4: rb = DIGITAL_VER;
            4'h5: rb = {3'h0, WAFER_WIDTH};
            4'h6: rb = WAFER_X;
            4'h7: rb = WAFER_Y;
            default: rb = tcrc_q;
        endcase
    end

    always_comb begin
        st_d = st_q;
        buf_d = buf_q;
        crc_d = crc_q;
        idx_d = idx_q;
        len_d = len_q;
        err_d = err_q;
        crcok_d = crcok_q;
        tidx_d = tidx_q;
        tcrc_d = tcrc_q;
        txd_d = txd_q;
        txv_d = txv_q;
        busy_d = busy_q;
        ees_d = eeprom_access_state_q;
        wr_d = 1'b0;
        rd_d = 1'b0;
        ferr_d = 1'b0;
        dev_d = ee_dev_q;
        addr_d = ee_addr_q;
        data_d = ee_data_q;
        pop = f_valid && (st_q == PBCF_D_IDLE || st_q == PBCF_D_RX);
        len_x = (idx_q == 4'h1) ? pbcf_frame_len(f_data[4:0]) : len_q;
        own = buf_q[0][4:0] == own_slave_address;
        take = 1'b0;
        if (ee_done) begin
            busy_d = 1'b0;
            ees_d = ee_fail ? `PBCF_EES_FAILED : `PBCF_EES_DONE;
        end
        case (st_q)
            PBCF_D_IDLE, PBCF_D_RX: begin
                if (pop && f_first) begin
                    // a new frame start always resynchronises the receiver
                    buf_d[0] = f_data;
                    idx_d = 4'h1;
                    crc_d = pbcf_crc_step(`PBCF_CRC_INIT, f_data);
                    err_d = pid_bad(f_data, `PBCF_FIRST_IDENTIFIER_BYTE_TAG);
                    st_d = PBCF_D_RX;
                end else if (pop && st_q == PBCF_D_RX) begin
                    buf_d[idx_q] = f_data;
                    idx_d = idx_q + 4'h1;
                    if (idx_q == 4'h1) begin
                        err_d = err_q || pid_bad(f_data, `PBCF_SECOND_IDENTIFIER_BYTE_TAG);
                        len_d = len_x;
                    end
                    if (idx_q == len_x - 4'h1) begin
                        crcok_d = f_data == crc_q;
                        st_d = PBCF_D_EXEC;
                    end else begin
                        crc_d = pbcf_crc_step(crc_q, f_data);
                    end
                end
            end
            PBCF_D_EXEC: begin
                st_d = PBCF_D_IDLE;
                if (err_q || !crcok_q) begin
                    ferr_d = 1'b1;
                end else if (buf_q[1][4:0] == `PBCF_SEL_IDENT) begin
                    if (own) begin
                        st_d = PBCF_D_REPLY;
                        tidx_d = 4'h0;
                        tcrc_d = `PBCF_CRC_INIT;
                    end
                end else if (buf_q[1][4:0] == `PBCF_SEL_EE_WR ||
                             buf_q[1][4:0] == `PBCF_SEL_EE_RD) begin
                    take = (own || buf_q[2][`PBCF_BCAST_BIT]) &&
                           buf_q[2][6:3] == 4'h0;
                end
                if (take && busy_q) begin
                    ees_d = `PBCF_EES_DENIED;
                end else if (take) begin
                    busy_d = 1'b1;
                    ees_d = `PBCF_EES_ONGOING;
                    wr_d = buf_q[1][4:0] == `PBCF_SEL_EE_WR;
                    rd_d = buf_q[1][4:0] == `PBCF_SEL_EE_RD;
                    dev_d = buf_q[2][2:0];
                    addr_d = buf_q[3];
                    for (int i = 0; i < 8; i++) begin
                        data_d[i*8 +: 8] = buf_q[`PBCF_EE_DATA_FIRST + i];
                    end
                end
            end
            PBCF_D_REPLY: begin
                if (!txv_q || link.s2m_ready) begin
                    if (tidx_q == `PBCF_LEN_IDENT_REPLY) begin
                        txv_d = 1'b0;
                        st_d = PBCF_D_IDLE;
                    end else begin
                        txv_d = 1'b1;
                        txd_d = rb;
                        tcrc_d = pbcf_crc_step(tcrc_q, rb);
                        tidx_d = tidx_q + 4'h1;
                    end
                end
            end
            default: st_d = PBCF_D_IDLE;
        endcase
    end

    always_comb begin
        rdata_d = 24'h000000;
        if (reg_rd && reg_addr == `PBCF_REG_MEAS_A) begin
            rdata_d = meas_a_q;
            if (external_channel_select == `PBCF_EXT_SEL_OFF) begin
                rdata_d[23:16] = 8'h00;
            end
        end else if (reg_rd && reg_addr == `PBCF_REG_MEAS_B) begin
            rdata_d = meas_b_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_q <= PBCF_D_IDLE;
            for (int i = 0; i < 13; i++) begin
                buf_q[i] <= 8'h00;
            end
            crc_q <= 8'h00;
            idx_q <= 4'h0;
            len_q <= 4'h0;
            err_q <= 1'b0;
            crcok_q <= 1'b0;
            tidx_q <= 4'h0;
            tcrc_q <= 8'h00;
            txd_q <= 8'h00;
            txv_q <= 1'b0;
            busy_q <= 1'b0;
            eeprom_access_state_q <= `PBCF_EES_RESET;
            ee_wr_q <= 1'b0;
            ee_rd_q <= 1'b0;
            ee_dev_q <= 3'h0;
            ee_addr_q <= 8'h00;
            ee_data_q <= 64'h0;
            frame_error_q <= 1'b0;
            meas_a_q <= `PBCF_MEAS_RESET;
            meas_b_q <= `PBCF_MEAS_RESET;
            reg_rdata_q <= 24'h000000;
        end else begin
            st_q <= st_d;
            buf_q <= buf_d;
            crc_q <= crc_d;
            idx_q <= idx_d;
            len_q <= len_d;
            err_q <= err_d;
            crcok_q <= crcok_d;
            tidx_q <= tidx_d;
            tcrc_q <= tcrc_d;
            txd_q <= txd_d;
            txv_q <= txv_d;
            busy_q <= busy_d;
            eeprom_access_state_q <= ees_d;
            ee_wr_q <= wr_d;
            ee_rd_q <= rd_d;
            ee_dev_q <= dev_d;
            ee_addr_q <= addr_d;
            ee_data_q <= data_d;
            frame_error_q <= ferr_d;
            if (meas_update) begin
                meas_a_q <= {external_channel_result, core_supply_result,
                             temperature_result};
                meas_b_q <= {overheat_threshold_code, string_voltage_result,
                             battery_voltage_result};
            end
            reg_rdata_q <= rdata_d;
        end
    end

    assign link.s2m_data = txd_q;
    assign link.s2m_valid = txv_q;
endmodule : pbcf_device

// *** rtl/pbcf_host.sv ***
`timescale 1ns/10ps
`include "pbcf_defines.svh"

module pbcf_host import pbcf_pkg::*; #(
    parameter int REPLY_TIMEOUT_CYC = `PBCF_REPLY_TIMEOUT_CYC
) (
    input wire logic clk_sys,
    input wire logic reset,
    pbcf_if.host link,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata_q
);
    pbcf_host_state_t st_q, st_d;
    logic [1:0] sel_q, sel_d;
    logic bc_q, bc_d, done_q, done_d, rerr_q, rerr_d, v_q, v_d, f_q, f_d, sr_q, sr_d;
    logic [4:0] sa_q, sa_d;
    logic [2:0] eeprom_device_address_q, eeprom_device_address_d;
    logic [7:0] eeprom_byte_address_q, eeprom_byte_address_d;
    logic [63:0] dat_q, dat_d;
    logic [3:0] idx_q, idx_d, len;
    pbcf_byte_t crc_q, crc_d, d_q, d_d, nb, p1, p2;
    pbcf_byte_t id_q [9];
    pbcf_byte_t id_d [9];
    logic [15:0] tmo_q, tmo_d;
    logic [31:0] rd_d;

    always_comb begin
        p1 = {1'b0, `PBCF_FIRST_IDENTIFIER_BYTE_TAG, sa_q};
        p1[7] = pbcf_parity(p1);
        p2 = {1'b0, `PBCF_SECOND_IDENTIFIER_BYTE_TAG, 3'h0, sel_q};
        p2[7] = pbcf_parity(p2);
        len = pbcf_frame_len({3'h0, sel_q});
        if (idx_q == 4'h0) begin
            nb = p1;
        end else if (idx_q == 4'h1) begin
            nb = p2;
        end else if (idx_q == len - 4'h1) begin
            nb = crc_q;
        end else if (idx_q == 4'h2) begin
            nb = {bc_q, 4'h0, eeprom_device_address_q};
        end else if (idx_q == 4'h3) begin
            nb = eeprom_byte_address_q;
        end else begin
            nb = dat_q[(idx_q - 4'h4)*8 +: 8];
        end
    end

    always_comb begin
        st_d = st_q;
        sel_d = sel_q;
        bc_d = bc_q;
        sa_d = sa_q;
        eeprom_device_address_d = eeprom_device_address_q;
        eeprom_byte_address_d = eeprom_byte_address_q;
        dat_d = dat_q;
        idx_d = idx_q;
        crc_d = crc_q;
        d_d = d_q;
        v_d = v_q;
        f_d = f_q;
        sr_d = 1'b0;
        done_d = done_q;
        rerr_d = rerr_q;
        id_d = id_q;
        tmo_d = tmo_q;
        if (wr && st_q == PBCF_H_IDLE) begin
            // writes while a frame is in flight are ignored
            if (addr == `PBCF_HREG_CMD) begin
                sel_d = wdata[1:0];
                bc_d = wdata[2];
                sa_d = wdata[12:8];
                st_d = PBCF_H_SEND;
                idx_d = 4'h0;
                crc_d = `PBCF_CRC_INIT;
                done_d = 1'b0;
                rerr_d = 1'b0;
            end else if (addr == `PBCF_HREG_EE_ADDR) begin
                eeprom_device_address_d = wdata[2:0];
                eeprom_byte_address_d = wdata[15:8];
            end else if (addr == `PBCF_HREG_DATA_LO) begin
                dat_d[31:0] = wdata;
            end else if (addr == `PBCF_HREG_DATA_HI) begin
                dat_d[63:32] = wdata;
            end
        end
        case (st_q)
            PBCF_H_SEND: begin
                if (!v_q || link.m2s_ready) begin
                    if (idx_q == len) begin
                        v_d = 1'b0;
                        idx_d = 4'h0;
                        crc_d = `PBCF_CRC_INIT;
                        tmo_d = 16'h0;
                        st_d = (sel_q == 2'h0) ? PBCF_H_WAIT : PBCF_H_DONE;
                    end else begin
                        v_d = 1'b1;
                        f_d = idx_q == 4'h0;
                        d_d = nb;
                        crc_d = pbcf_crc_step(crc_q, nb);
                        idx_d = idx_q + 4'h1;
                    end
                end
            end
            PBCF_H_WAIT: begin
                sr_d = 1'b1;
                tmo_d = tmo_q + 16'h1;
                if (link.s2m_valid && sr_q) begin
                    id_d[idx_q] = link.s2m_data;
                    idx_d = idx_q + 4'h1;
                    crc_d = pbcf_crc_step(crc_q, link.s2m_data);
                    if (idx_q == `PBCF_LEN_IDENT_REPLY - 4'h1) begin
                        rerr_d = link.s2m_data != crc_q;
                        sr_d = 1'b0;
                        st_d = PBCF_H_DONE;
                    end
                end else if (tmo_q == 16'(REPLY_TIMEOUT_CYC - 1)) begin
                    rerr_d = 1'b1;
                    sr_d = 1'b0;
                    st_d = PBCF_H_DONE;
                end
            end
            PBCF_H_DONE: begin
                done_d = 1'b1;
                st_d = PBCF_H_IDLE;
            end
            default: ;
        endcase
    end

    always_comb begin
        rd_d = 32'h0;
        if (rd && addr == `PBCF_HREG_STATUS) begin
            rd_d = {29'h0, rerr_q, done_q, st_q != PBCF_H_IDLE};
        end else if (rd && addr == `PBCF_HREG_ID0) begin
            rd_d = {id_q[5], id_q[4], id_q[3], id_q[2]};
        end else if (rd && addr == `PBCF_HREG_ID1) begin
            rd_d = {16'h0, id_q[7], id_q[6]};
        end else if (rd && addr == `PBCF_HREG_EE_ADDR) begin
            rd_d = {16'h0, eeprom_byte_address_q, 5'h0, eeprom_device_address_q};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_q <= PBCF_H_IDLE;
            sel_q <= 2'h0;
            bc_q <= 1'b0;
            sa_q <= 5'h00;
            eeprom_device_address_q <= 3'h0;
            eeprom_byte_address_q <= 8'h00;
            dat_q <= 64'h0;
            idx_q <= 4'h0;
            crc_q <= 8'h00;
            d_q <= 8'h00;
            v_q <= 1'b0;
            f_q <= 1'b0;
            sr_q <= 1'b0;
            done_q <= 1'b0;
            rerr_q <= 1'b0;
            for (int i = 0; i < 9; i++) begin
                id_q[i] <= 8'h00;
            end
            tmo_q <= 16'h0;
            rdata_q <= 32'h0;
        end else begin
            st_q <= st_d;
            sel_q <= sel_d;
            bc_q <= bc_d;
            sa_q <= sa_d;
            eeprom_device_address_q <= eeprom_device_address_d;
            eeprom_byte_address_q <= eeprom_byte_address_d;
            dat_q <= dat_d;
            idx_q <= idx_d;
            crc_q <= crc_d;
            d_q <= d_d;
            v_q <= v_d;
            f_q <= f_d;
            sr_q <= sr_d;
            done_q <= done_d;
            rerr_q <= rerr_d;
            id_q <= id_d;
            tmo_q <= tmo_d;
            rdata_q <= rd_d;
        end
    end

    assign link.m2s_data = d_q;
    assign link.m2s_first = f_q;
    assign link.m2s_valid = v_q;
    assign link.s2m_ready = sr_q;
endmodule : pbcf_host

// *** verification/pbcf_link_chk.sv ***
`timescale 1ns/10ps
module pbcf_link_chk (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [7:0] m2s_data,
    input wire logic m2s_first,
    input wire logic m2s_valid,
    input wire logic m2s_ready,
    input wire logic [7:0] s2m_data,
    input wire logic s2m_valid,
    input wire logic s2m_ready
);
    logic second_identifier_byte_q;
    logic [3:0] rcnt_q;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    // only identification replies exist, so the index wraps after nine bytes
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            second_identifier_byte_q <= 1'b0;
            rcnt_q <= 4'h0;
        end else begin
            if (m2s_valid && m2s_ready) begin
                second_identifier_byte_q <= m2s_first;
            end
            if (s2m_valid && s2m_ready) begin
                rcnt_q <= (rcnt_q == 4'h8) ? 4'h0 : rcnt_q + 4'h1;
            end
        end
    end
    property p_rst; $fell(reset) |-> !m2s_ready && !m2s_valid && !s2m_valid ##1 m2s_ready; endproperty
    property p_m2s_hold; m2s_valid && !m2s_ready |=> m2s_valid && $stable(m2s_data); endproperty
    property p_s2m_hold; s2m_valid && !s2m_ready |=> s2m_valid && $stable(s2m_data); endproperty
    property p_first_identifier_byte; m2s_valid && m2s_first |-> m2s_data[7:5] == {^m2s_data[6:0], 2'h3}; endproperty
    property p_second_identifier_byte; second_identifier_byte_q && m2s_valid && !m2s_first |-> m2s_data[7:2] == {^m2s_data[6:0], 5'h00};
    endproperty
    property p_rpid1; s2m_valid && rcnt_q == 4'h0 |-> s2m_data[7:5] == {^s2m_data[6:0], 2'h3};
    endproperty
    property p_rpid2; s2m_valid && rcnt_q == 4'h1 |-> s2m_data == 8'h00; endproperty
    property p_width; s2m_valid && rcnt_q == 4'h5 |-> s2m_data[7:5] == 3'h0; endproperty
    a_rst: assert property (p_rst) else $error("link not idle after reset");
    a_m2s_hold: assert property (p_m2s_hold) else $error("request byte dropped");
    a_s2m_hold: assert property (p_s2m_hold) else $error("reply byte dropped");
    a_first_identifier_byte: assert property (p_first_identifier_byte) else $error("first identifier bad");
    a_second_identifier_byte: assert property (p_second_identifier_byte) else $error("second identifier bad");
    a_rpid1: assert property (p_rpid1) else $error("reply first identifier bad");
    a_rpid2: assert property (p_rpid2) else $error("reply second identifier bad");
    a_width: assert property (p_width) else $error("width byte top bits set");
    c_req: cover property (m2s_valid && m2s_ready && m2s_first);
    c_reply: cover property (s2m_valid && s2m_ready && rcnt_q == 4'h8);
    c_stall: cover property (m2s_valid && !m2s_ready);
endmodule : pbcf_link_chk

// *** verification/tb_pixel_bus_config_frames.sv ***
`timescale 1ns/10ps
module tb_pixel_bus_config_frames;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata_q;
    logic meas_update = 1'b0;
    logic [47:0] meas = 48'h0;
    logic [1:0] ext_sel = 2'h0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [23:0] reg_rdata_q;
    logic ee_wr_q, ee_rd_q, frame_error_q, ee_done = 1'b0, ee_fail = 1'b0;
    logic [2:0] ee_dev_q;
    logic [7:0] ee_addr_q;
    logic [63:0] ee_data_q;
    logic [1:0] st;
    logic [31:0] v;
    int fails = 0, checked = 0, nwr = 0, nrd = 0, nfe = 0;
    pbcf_if link_if ();
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        nwr <= nwr + (ee_wr_q === 1'b1);
        nrd <= nrd + (ee_rd_q === 1'b1);
        nfe <= nfe + (frame_error_q === 1'b1);
    end
    pbcf_host #(.REPLY_TIMEOUT_CYC(50)) pbcf_host_inst (.clk_sys(clk_sys), .reset(reset),
        .link(link_if), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q));
    pbcf_device #(.WAFER_WIDTH(5'h15), .WAFER_X(8'h3c), .WAFER_Y(8'hc3)) pbcf_device_inst (
        .clk_sys(clk_sys), .reset(reset), .link(link_if), .own_slave_address(5'h09),
        .meas_update(meas_update), .temperature_result(meas[7:0]),
        .core_supply_result(meas[15:8]), .external_channel_result(meas[23:16]),
        .external_channel_select(ext_sel), .battery_voltage_result(meas[31:24]),
        .string_voltage_result(meas[39:32]), .overheat_threshold_code(meas[47:40]),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata_q(reg_rdata_q), .ee_wr_q(ee_wr_q),
        .ee_rd_q(ee_rd_q), .ee_dev_q(ee_dev_q), .ee_addr_q(ee_addr_q), .ee_data_q(ee_data_q),
        .ee_done(ee_done), .ee_fail(ee_fail), .eeprom_access_state_q(st),
        .frame_error_q(frame_error_q));
    pbcf_link_chk pbcf_link_chk_inst (.clk_sys(clk_sys), .reset(reset),
        .m2s_data(link_if.m2s_data), .m2s_first(link_if.m2s_first),
        .m2s_valid(link_if.m2s_valid), .m2s_ready(link_if.m2s_ready),
        .s2m_data(link_if.s2m_data), .s2m_valid(link_if.s2m_valid),
        .s2m_ready(link_if.s2m_ready));
    task finish_test;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test
    task chk(input logic [63:0] s, input logic [63:0] e);
        checked++;
        if (s !== e) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, s, e);
        end
    endtask : chk
    task hwr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask : hwr
    // one read task for both ports keeps their timing identical
    task rdx(input logic dev, input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        reg_addr <= a;
        rd <= !dev;
        reg_rd <= dev;
        @(posedge clk_sys);
        rd <= 1'b0;
        reg_rd <= 1'b0;
        #1 d = dev ? {8'h00, reg_rdata_q} : rdata_q;
    endtask : rdx
    task cmd(input logic [31:0] c);
        int i;
        // a stale done from the previous command must not end the poll early
        v = 32'h0;
        hwr(8'h00, c);
        for (i = 0; i < 100 && v[1:0] !== 2'b10; i++) begin
            rdx(1'b0, 8'h10, v);
        end
        if (i == 100) begin
            chk(v[1:0], 2'b10);
            finish_test();
        end
    endtask : cmd
    task wcnt(input int w, input int r);
        for (int i = 0; i < 50 && !(nwr == w && nrd == r); i++) begin
            @(posedge clk_sys);
            #1;
        end
        chk(nwr, w);
        chk(nrd, r);
    endtask : wcnt
    task done_ee(input logic f, input logic [1:0] e);
        @(posedge clk_sys);
        ee_done <= 1'b1;
        ee_fail <= f;
        @(posedge clk_sys);
        ee_done <= 1'b0;
        @(posedge clk_sys);
        #1 chk(st, e);
    endtask : done_ee
    initial begin
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 chk(st, 2'h2);
        rdx(1'b1, 8'h11, v);
        chk(v, 32'h0);
        rdx(1'b1, 8'h12, v);
        chk(v, 32'h0);
        @(posedge clk_sys);
        meas <= 48'hc6b5a4938271;
        meas_update <= 1'b1;
        @(posedge clk_sys);
        meas_update <= 1'b0;
        meas <= 48'h0;
        rdx(1'b1, 8'h11, v);
        chk(v, 32'h00938271);
        rdx(1'b1, 8'h12, v);
        chk(v, 32'h00c6b5a4);
        @(posedge clk_sys);
        ext_sel <= 2'h3;
        rdx(1'b1, 8'h11, v);
        chk(v, 32'h00008271);
        $display("test registers done");
        cmd(32'h00000900);
        chk(v[2], 1'b0);
        rdx(1'b0, 8'h14, v);
        chk(v, 32'h150b0a5a);
        rdx(1'b0, 8'h18, v);
        chk(v, 32'h0000c33c);
        cmd(32'h00000a00);
        chk(v[2], 1'b1);
        $display("test identification done");
        hwr(8'h04, 32'h0000ff05);
        hwr(8'h08, 32'h33221100);
        hwr(8'h0c, 32'h77665544);
        cmd(32'h00000901);
        wcnt(1, 0);
        chk(ee_data_q, 64'h7766554433221100);
        chk({ee_dev_q, ee_addr_q}, 11'h5ff);
        chk(st, 2'h1);
        cmd(32'h00000902);
        wcnt(1, 0);
        chk(st, 2'h0);
        done_ee(1'b0, 2'h2);
        cmd(32'h00000a01);
        cmd(32'h00000903);
        cmd(32'h00001306);
        wcnt(1, 1);
        chk({ee_dev_q, ee_addr_q}, 11'h5ff);
        done_ee(1'b1, 2'h3);
        chk(nfe, 0);
        $display("test eeprom done");
        finish_test();
    end
endmodule : tb_pixel_bus_config_frames
